/* common/histo_defines.svh */
// Constants for the histogram buffer host port
`ifndef HISTO_DEFINES_SVH
`define HISTO_DEFINES_SVH

`define CMD_START          16'h8001
`define CMD_STOP           16'h8000
`define CMD_CMD_BIT        15
`define TIMER_MS_PER_SEC   1000
`define CLK_HZ             40000000
`define TICK_NS            1000000
`define ACK_LAG_NS         50
`define FULL_PULSE_NS      150
`define READ_MAX_NS        1000
`define PERIOD_NS          25
`define ACK_LAG_CYC        ((`ACK_LAG_NS + `PERIOD_NS - 1) / `PERIOD_NS)
`define FULL_PULSE_CYC     (`FULL_PULSE_NS / `PERIOD_NS)
`define READ_MAX_CYC       (`READ_MAX_NS / `PERIOD_NS)
`define TICK_CYC           (`TICK_NS / `PERIOD_NS)
`define FULL_COUNT         16'hFFFF
`define CHAN_COUNT         4096

`endif

/* common/histo_pkg.sv */
// Types for the histogram buffer host port
package histo_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DECO  = 3'b001,
    ST_READ  = 3'b011,
    ST_WAITR = 3'b010,
    ST_TIMED = 3'b110,
    ST_DONE  = 3'b111
  } port_state_t;

endpackage

/* design/histo_host_port.sv */
// Histogram double buffer with parallel host command and data port
`include "histo_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module histo_host_port
  import histo_pkg::*;
#(
  parameter int TICK_CYC = `TICK_CYC,
  parameter int XW       = 10,
  parameter int AW       = 12
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  input  wire logic [XW-1:0] x_coord_i,
  input  wire logic          x_strobe_i,
  input  wire logic          x_rate_i,
  input  wire logic [XW-1:0] y_coord_i,
  input  wire logic          y_strobe_i,
  input  wire logic          y_rate_i,
  input  wire logic [15:0]   host_out_i,
  input  wire logic          direction_i,
  input  wire logic          transfer_request_i,
  output logic      [15:0]   host_in_o,
  output logic               ready_ack_flag_o,
  output logic               running_o
);

  localparam int DEPTH = `CHAN_COUNT;
  localparam int HALF  = AW / 2;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [XW-1:0] x_s, y_s;
  logic [15:0]   cmd_s;
  logic          xs_s, ys_s, xr_s, yr_s, dir_s, req_s;

  sync2 #(.W(2*XW+4)) u_sync_xy (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({x_coord_i, y_coord_i, x_strobe_i, y_strobe_i,
              x_rate_i, y_rate_i}),
    .q_o    ({x_s, y_s, xs_s, ys_s, xr_s, yr_s})
  );

  sync2 #(.W(18)) u_sync_host (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({host_out_i, direction_i, transfer_request_i}),
    .q_o    ({cmd_s, dir_s, req_s})
  );

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  logic req_d, xs_d, ys_d, x_seen, y_seen;
  logic req_fall;
  assign req_fall = req_d & ~req_s;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      req_d <= 1'b0; // Synchroniser resets low; avoids a false fall
      xs_d  <= 1'b0;
      ys_d  <= 1'b0;
    end else begin
      req_d <= req_s;
      xs_d  <= xs_s;
      ys_d  <= ys_s;
    end
  end

  // Pair X and Y strobes; coordinate counted once both arrive while running
  logic event_go;
  assign event_go = (x_seen | (xs_s & ~xs_d)) & (y_seen | (ys_s & ~ys_d));

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      x_seen <= 1'b0;
      y_seen <= 1'b0;
    end else if (event_go) begin
      x_seen <= 1'b0;
      y_seen <= 1'b0;
    end else begin
      x_seen <= x_seen | (xs_s & ~xs_d);
      y_seen <= y_seen | (ys_s & ~ys_d);
    end
  end

  // ------------------------------------------------------------
  // Double buffer memory
  // ------------------------------------------------------------
  logic [15:0]   mem [0:2*DEPTH-1];
  logic          in_sel;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   ev_addr;
  logic [15:0]   ev_val;
  logic          ev_busy, full_hit;

  function automatic logic [AW:0] chan_addr(input logic bank,
                                            input logic [AW-1:0] idx);
    chan_addr = {bank, idx};
  endfunction

  // ------------------------------------------------------------
  // Command state machine
  // ------------------------------------------------------------
  port_state_t   state;
  logic [15:0]   timer_val;
  logic [15:0]   ms_left;
  logic          tick, rd_go;
  logic [3:0]    pulse_cnt;

  ms_divider #(.DIV(TICK_CYC)) u_div (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .clear_i (state != ST_TIMED),
    .tick_o  (tick)
  );

  assign rd_go = (state == ST_READ) & ~ev_busy;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state        <= ST_IDLE;
      timer_val    <= 16'h0;
      running_o    <= 1'b0;
      in_sel       <= 1'b0;
      ms_left      <= 16'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req_fall) begin
            state <= ST_DECO;
          end
        end
        ST_DECO: begin
          if (dir_s) begin
            state    <= ST_READ;
          end else if (cmd_s == `CMD_START) begin
            running_o <= 1'b1;
            in_sel    <= ~in_sel;
            if (timer_val != 16'h0) begin
              ms_left <= timer_val;
              state   <= ST_TIMED;
            end else begin
              state <= ST_WAITR;
            end
          end else if (cmd_s == `CMD_STOP) begin
            running_o <= 1'b0;
            state     <= ST_DONE;
          end else begin
            timer_val <= cmd_s;
            state     <= ST_WAITR;
          end
        end
        ST_READ: begin
          if (rd_go) begin
            state <= ST_DONE;
          end
        end
        ST_WAITR: begin
          if (req_s) begin
            state <= ST_DONE;
          end
        end
        ST_TIMED: begin
          if (tick) begin
            if (ms_left == 16'h1) begin
              running_o <= 1'b0;
              state     <= ST_DONE;
            end
            ms_left <= ms_left - 16'h1;
          end
        end
        ST_DONE: begin
          if (req_s) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Read pointer and destructive readout of the output bank
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_ptr    <= '0;
      host_in_o <= 16'h0;
    end else if (rd_go) begin
      host_in_o <= mem[chan_addr(~in_sel, rd_ptr)];
      rd_ptr    <= rd_ptr + 1'b1;
    end
  end

  // Accumulation: read-modify-write, stalls reads while busy
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_busy  <= 1'b0;
      ev_addr  <= '0;
      ev_val   <= 16'h0;
      full_hit <= 1'b0;
    end else begin
      full_hit <= 1'b0;
      if (ev_busy) begin
        ev_busy <= 1'b0;
        if (ev_val == `FULL_COUNT - 16'h1) begin
          full_hit <= 1'b1;
        end
      end else if (event_go && running_o) begin
        ev_busy <= 1'b1;
        ev_addr <= chan_addr(in_sel,
                             {x_s[XW-1 -: HALF], y_s[XW-1 -: HALF]});
        ev_val  <= mem[chan_addr(in_sel,
                             {x_s[XW-1 -: HALF], y_s[XW-1 -: HALF]})];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (ev_busy && ev_val != `FULL_COUNT) begin
      mem[ev_addr] <= ev_val + 16'h1;
    end else if (rd_go) begin
      mem[chan_addr(~in_sel, rd_ptr)] <= 16'h0;
    end
  end

  // ------------------------------------------------------------
  // Ready flag
  // ------------------------------------------------------------
  logic busy;
  assign busy = (state != ST_IDLE) & ~(state == ST_DONE & req_s);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_cnt <= 4'h0;
    end else if (full_hit && running_o && timer_val == 16'h0) begin
      pulse_cnt <= 4'(`FULL_PULSE_CYC);
    end else if (pulse_cnt != 4'h0) begin
      pulse_cnt <= pulse_cnt - 4'h1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_ack_flag_o <= 1'b1;
    end else begin
      ready_ack_flag_o <= ~(busy | (pulse_cnt != 4'h0));
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_ack_follows;
    @(posedge mclk_i) disable iff (rst_i)
      req_fall |-> ##2 !ready_ack_flag_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("flag did not drop after request");

  property p_idle_high;
    @(posedge mclk_i) disable iff (rst_i)
      (state == ST_IDLE && pulse_cnt == 4'h0) |=> ready_ack_flag_o;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("flag low while idle");

  property p_read_bound;
    @(posedge mclk_i) disable iff (rst_i)
      $rose(state == ST_READ) |-> ##[1:40] (state == ST_DONE);
  endproperty
  a_read_bound: assert property (p_read_bound)
    else $error("read took over one microsecond");

  sequence s_start;
    state == ST_DECO && !dir_s && cmd_s == `CMD_START;
  endsequence
  property p_start_runs;
    @(posedge mclk_i) disable iff (rst_i)
      s_start |=> running_o && (in_sel != $past(in_sel));
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("start did not swap and run");

  property p_stop;
    @(posedge mclk_i) disable iff (rst_i)
      (state == ST_DECO && !dir_s && cmd_s == `CMD_STOP) |=> !running_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not halt");

  property p_timed_low;
    @(posedge mclk_i) disable iff (rst_i)
      (state == ST_TIMED) |=> !ready_ack_flag_o;
  endproperty
  a_timed_low: assert property (p_timed_low)
    else $error("flag high during timed interval");

  property p_untimed_release;
    @(posedge mclk_i) disable iff (rst_i)
      (state == ST_WAITR && req_s) |-> ##2 ready_ack_flag_o;
  endproperty
  a_untimed_release: assert property (p_untimed_release)
    else $error("flag not released after request high");

  property p_full_pulse;
    @(posedge mclk_i) disable iff (rst_i)
      (full_hit && running_o && timer_val == 16'h0)
        |=> ##1 (!ready_ack_flag_o) [*6];
  endproperty
  a_full_pulse: assert property (p_full_pulse)
    else $error("full pulse too short");

endmodule

`default_nettype wire

/* design/ms_divider.sv */
// Divider giving one-cycle enable pulses at the timer tick rate
`timescale 1ns/10ps
`default_nettype none

module ms_divider #(
  parameter int DIV = 40000
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic clear_i,
  output logic      tick_o
);

  logic [31:0] count;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      count  <= 32'h0;
      tick_o <= 1'b0;
    end else if (clear_i) begin
      count  <= 32'h0;
      tick_o <= 1'b0;
    end else if (count == 32'(DIV - 1)) begin
      count  <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 32'h1;
      tick_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* design/sync2.sv */
// Two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] stage1;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      q_o    <= '0;
    end else begin
      stage1 <= d_i;
      q_o    <= stage1;
    end
  end

endmodule

`default_nettype wire

/* verification/histogram_buffer_host_handshake_tb.sv */
// Self-checking bench for the histogram host port
`timescale 1ns/10ps
`default_nettype none

module histogram_buffer_host_handshake_tb;
  typedef struct {
    logic [15:0] word;
    int          hold;
    logic        run;
    int          hi;
  } row_t;

  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic [9:0]  x_coord;
  logic [9:0]  y_coord;
  logic        x_strobe;
  logic        y_strobe;
  wire  [15:0] host_out;
  wire  [15:0] host_in;
  wire         direction;
  wire         transfer_request;
  wire         ready_ack_flag;
  wire         running;
  int          err_count = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  int          lowc;
  logic [15:0] rd;
  logic        ok;
  row_t        rows[3] = '{'{16'h0000, 2, 1'b0, 8},
                           '{16'h8001, 6, 1'b1, 8},
                           '{16'h8000, 0, 1'b0, 40}};

  histo_host_port #(.TICK_CYC(4)) histo_host_port_i (
    .mclk_i(mclk_i), .rst_i(rst_i),
    .x_coord_i(x_coord), .x_strobe_i(x_strobe), .x_rate_i(1'b0),
    .y_coord_i(y_coord), .y_strobe_i(y_strobe), .y_rate_i(1'b0),
    .host_out_i(host_out), .direction_i(direction),
    .transfer_request_i(transfer_request), .host_in_o(host_in),
    .ready_ack_flag_o(ready_ack_flag), .running_o(running));

  host_model host_model_i (
    .mclk_i(mclk_i), .ready_ack_flag_i(ready_ack_flag),
    .host_in_i(host_in), .host_out_o(host_out),
    .direction_o(direction), .transfer_request_o(transfer_request));

  always #12.5 mclk_i = ~mclk_i;

  // Full clear of one bank dominates the run time
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      results();
    end
  end

  task check(input string what, input logic [15:0] exp,
             input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task check_rng(input string what, input int lo, input int hi,
                 input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task cmd(input logic dir, input logic [15:0] w, input int hold,
           input int lim);
    host_model_i.xfer(dir, w, hold, lim, rd, lowc, ok);
    check("handshake", 16'h0001, {15'h0, ok});
  endtask

  task automatic hit(input logic [9:0] x, input logic [9:0] y,
                     input int n);
    repeat (n) begin
      @(negedge mclk_i);
      x_coord = x;
      y_coord = y;
      @(negedge mclk_i);
      x_strobe = 1'b1;
      y_strobe = 1'b1;
      repeat (3) @(negedge mclk_i);
      x_strobe = 1'b0;
      y_strobe = 1'b0;
      repeat (3) @(negedge mclk_i);
    end
  endtask

  task check_idle();
    check("flag", 16'h0001, {15'h0, ready_ack_flag});
    check("running", 16'h0000, {15'h0, running});
    check("data", 16'h0000, host_in);
  endtask

  task results();
    $display("Compares %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    x_coord  = 10'h000;
    y_coord  = 10'h000;
    x_strobe = 1'b0;
    y_strobe = 1'b0;
    repeat (4) @(negedge mclk_i);
    rst_i = 1'b0;
    check_idle();
    repeat (3) @(negedge mclk_i);
    foreach (rows[i]) begin
      cmd(1'b0, rows[i].word, rows[i].hold, 40);
      check_rng("release", 0, rows[i].hi, lowc);
      check("running", {15'h0, rows[i].run}, {15'h0, running});
    end
    // Memory powers up unknown, so the output bank is read clean
    repeat (4096) begin
      cmd(1'b1, 16'h0000, 0, 40);
      check_rng("read time", 0, 40, lowc);
    end
    cmd(1'b0, 16'h8001, 0, 40);
    hit(10'h000, 10'h000, 3);
    hit(10'h000, 10'h010, 2);
    cmd(1'b0, 16'h8000, 0, 40);
    hit(10'h000, 10'h000, 2);
    cmd(1'b0, 16'h8001, 0, 40);
    cmd(1'b0, 16'h8000, 0, 40);
    cmd(1'b1, 16'h0000, 0, 40);
    check("chan0", 16'h0003, rd);
    cmd(1'b1, 16'h0000, 0, 40);
    check("chan1", 16'h0002, rd);
    cmd(1'b1, 16'h0000, 0, 40);
    check("chan2", 16'h0000, rd);
    @(negedge mclk_i);
    rst_i = 1'b1;
    @(negedge mclk_i);
    rst_i = 1'b0;
    check_idle();
    repeat (3) @(negedge mclk_i);
    cmd(1'b0, 16'd1000, 0, 40);
    check_rng("timer load", 0, 8, lowc);
    cmd(1'b0, 16'h8001, 0, 5000);
    check_rng("timed interval", 3985, 4010, lowc);
    results();
  end
endmodule
`default_nettype wire

/* verification/host_model.sv */
// Host parallel card model that drives the command and read port
`timescale 1ns/10ps
`default_nettype none

module host_model (
  input  wire logic        mclk_i,
  input  wire logic        ready_ack_flag_i,
  input  wire logic [15:0] host_in_i,
  output logic      [15:0] host_out_o,
  output logic             direction_o,
  output logic             transfer_request_o
);
  initial begin
    host_out_o         = 16'h0000;
    direction_o        = 1'b0;
    transfer_request_o = 1'b1;
  end

  // ----------------------------------------
  // One transfer, request held hold cycles
  // ----------------------------------------
  // Bus toggles when unused so stale words never look valid
  task automatic xfer(input logic dir, input logic [15:0] word,
                      input int hold, input int lim,
                      output logic [15:0] rd, output int lowc,
                      output logic ok);
    int n;
    begin
      n = 0;
      @(negedge mclk_i);
      direction_o = dir;
      host_out_o = dir ? ~host_out_o : word;
      @(negedge mclk_i);
      transfer_request_o = 1'b0;
      while (ready_ack_flag_i !== 1'b0 && n < 40) begin
        @(negedge mclk_i);
        n++;
      end
      ok = (ready_ack_flag_i === 1'b0);
      repeat (hold) @(negedge mclk_i);
      transfer_request_o = 1'b1;
      lowc = 0;
      while (ready_ack_flag_i !== 1'b1 && lowc < lim) begin
        @(negedge mclk_i);
        lowc++;
      end
      ok = ok && (ready_ack_flag_i === 1'b1);
      rd = host_in_i;
      host_out_o = ~host_out_o;
    end
  endtask
endmodule
`default_nettype wire
